// >>> rtl/pmr_pkg.sv
// Shared constants and types for the MAC-side data port.
// Assumes one core clock and one link clock, mutually asynchronous.
package pmr_pkg;

    // ---------------------------------------------------------------
    // Interface selection at reset
    // ---------------------------------------------------------------
    localparam logic [1:0] MODE_RMII = 2'h0;
    localparam logic [1:0] MODE_MII = 2'h1;

    // ---------------------------------------------------------------
    // Ability bit positions in the advertised set
    // ---------------------------------------------------------------
    localparam int ADV_100F = 3;
    localparam int ADV_100H = 2;
    localparam int ADV_10F = 1;
    localparam int ADV_10H = 0;
    localparam logic [3:0] ADV_RESET = 4'h0;

    // ---------------------------------------------------------------
    // Timing counts and fifo shape
    // ---------------------------------------------------------------
    localparam int RMII_10M_HOLD = 10;                  // Ref clocks per di-bit at 10M
    localparam logic [3:0] HOLD_LAST = 4'(RMII_10M_HOLD - 1);
    localparam int FILL_BITS = 12;                      // Bits buffered before output in RMII
    localparam logic [3:0] FILL_NIBBLES = 4'((FILL_BITS + 3) / 4);
    localparam int FIFO_AW = 3;
    localparam int FIFO_W = 5;                          // Error flag plus nibble
    localparam int FIFO_DEPTH = 1 << FIFO_AW;

    // ---------------------------------------------------------------
    // Data patterns
    // ---------------------------------------------------------------
    localparam logic [3:0] NIB_SYMERR = 4'h5;
    localparam logic [3:0] NIB_FALSE = 4'hE;
    localparam logic [1:0] DIBIT_SFD = 2'h3;
    localparam logic [1:0] DIBIT_PRE = 2'h1;

    // Receive sequencer, Gray coded along idle, fill, data
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_FILL = 2'h1,
        RX_DATA = 2'h3
    } pmr_rx_e;

endpackage

// >>> rtl/pmr_sync.sv
// Three-stage level synchroniser with agreement filter.
// Assumes the input is a level; each bit settles independently.
`timescale 1ns/10ps
module pmr_sync #(
    parameter int W = 1
) (
    input wire logic clk,          // Destination clock
    input wire logic [W-1:0] d,    // Level from another domain
    output logic [W-1:0] q         // Filtered level
);
    import pmr_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } pmr_sync_s;

    pmr_sync_s r_q, r_d;

    // Stage one feeds stage two only; output moves when two and three agree
    always_comb begin
        r_d = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        r_d.q = (r_q.s2 & r_q.s3) | (r_q.q & (r_q.s2 | r_q.s3));
    end

    // No reset: the destination reset itself may pass through here
    always_ff @(posedge clk) begin
        r_q <= r_d;
    end

    assign q = r_q.q;
endmodule

// >>> rtl/pmr_rx_fifo.sv
// Resynchronising receive fifo, core clock in, link clock out.
// Assumes show-ahead reads; pointers cross Gray coded.
`timescale 1ns/10ps
module pmr_rx_fifo (
    input wire logic wclk,                          // Write clock
    input wire logic wrst,                          // Write-side reset
    input wire logic w_valid,                       // Write request
    input wire logic [pmr_pkg::FIFO_W-1:0] w_data,  // Write entry
    output logic w_ready,                           // Not full
    input wire logic rclk,                          // Read clock
    input wire logic rrst,                          // Read-side reset
    input wire logic r_pop,                         // Consume head
    output logic [pmr_pkg::FIFO_W-1:0] r_data,      // Head entry
    output logic [pmr_pkg::FIFO_AW:0] r_level       // Entries held
);
    import pmr_pkg::*;

    typedef struct packed {
        logic [FIFO_AW:0] bin;
        logic [FIFO_AW:0] gray;
        logic [FIFO_AW:0] g1;
        logic [FIFO_AW:0] g2;
    } pmr_ptr_s;

    logic [FIFO_W-1:0] mem [FIFO_DEPTH];
    pmr_ptr_s w_q, w_d, rd_q, rd_d;

    function automatic logic [FIFO_AW:0] g2b(input logic [FIFO_AW:0] g);
        logic [FIFO_AW:0] b;
        b = '0;
        for (int i = FIFO_AW; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == FIFO_AW) ? 1'b0 : b[i+1]);
        end
        return b;
    endfunction

    // Full when the far pointer differs only in the two top bits
    assign w_ready = w_q.gray != {~w_q.g2[FIFO_AW:FIFO_AW-1], w_q.g2[FIFO_AW-2:0]};
    assign r_data = mem[rd_q.bin[FIFO_AW-1:0]];
    assign r_level = g2b(rd_q.g2) - rd_q.bin;

    // Write side pointer and read-pointer synchroniser
    always_comb begin
        w_d = w_q;
        w_d.g1 = rd_q.gray;
        w_d.g2 = w_q.g1;
        if (w_valid && w_ready) begin
            w_d.bin = w_q.bin + 1'b1;
            w_d.gray = w_d.bin ^ (w_d.bin >> 1);
        end
    end

    always_ff @(posedge wclk) begin
        if (wrst) begin
            w_q <= '0;
        end else begin
            w_q <= w_d;
        end
    end

    // Storage is written only from the write domain
    always_ff @(posedge wclk) begin
        if (w_valid && w_ready) begin
            mem[w_q.bin[FIFO_AW-1:0]] <= w_data;
        end
    end

    // Read side pointer and write-pointer synchroniser
    always_comb begin
        rd_d = rd_q;
        rd_d.g1 = w_q.gray;
        rd_d.g2 = rd_q.g1;
        if (r_pop && r_level != '0) begin
            rd_d.bin = rd_q.bin + 1'b1;
            rd_d.gray = rd_d.bin ^ (rd_d.bin >> 1);
        end
    end

    always_ff @(posedge rclk) begin
        if (rrst) begin
            rd_q <= '0;
        end else begin
            rd_q <= rd_d;
        end
    end
endmodule

// >>> rtl/pmr_port.sv
// MAC-facing data port of a 10/100 transceiver: RMII or MII, straps.
// Assumes the line side delivers nibbles and status on mclk, and the
// MAC-side reference or data clock arrives on link_clk.
`timescale 1ns/10ps

module pmr_port (
    input wire logic mclk,                   // Core clock
    input wire logic reset,                  // Core reset, active high
    input wire logic link_clk,               // RMII reference or MII data clock
    input wire logic autoneg_enable_strap,   // Strap pin
    input wire logic speed_select_strap,     // Strap pin, 1 = 100M
    input wire logic duplex_select_strap,    // Strap pin, 1 = full
    input wire logic [1:0] mode_strap,       // Strap pins, interface type
    input wire logic neg_speed100,           // Negotiated speed
    input wire logic neg_full_duplex,        // Negotiated duplex
    input wire logic phy_rx_carrier,         // Line carrier detected
    input wire logic phy_rx_valid,           // Recovered data valid
    input wire logic [3:0] phy_rx_nibble,    // Recovered nibble
    input wire logic phy_rx_strobe,          // Nibble ready
    input wire logic phy_false_carrier,      // False carrier seen
    input wire logic phy_symbol_error,       // Symbol error in packet
    output logic [3:0] adv_ability,          // Advertised abilities
    output logic bmcr_an_enable,             // Default autoneg enable
    output logic bmcr_speed100,              // Default speed
    output logic bmcr_full_duplex,           // Default duplex
    output logic [3:0] phy_tx_nibble,        // Nibble to line
    output logic phy_tx_strobe,              // Nibble pulse
    output logic phy_tx_active,              // Transmit in progress
    output logic col,                        // MII collision
    output logic crs,                        // MII carrier sense
    input wire logic tx_en,                  // Transmit enable, link clock
    input wire logic [3:0] txd,              // Transmit data, link clock
    output logic [3:0] rxd,                  // Receive data, RMII uses [1:0]
    output logic rx_dv,                      // MII receive valid
    output logic carrier_valid_pin,          // RMII carrier-valid
    output logic rx_er                       // Receive error
);
    import pmr_pkg::*;

    // ---------------------------------------------------------------
    // State records
    // ---------------------------------------------------------------
    typedef struct packed {
        logic an;
        logic spd;
        logic dup;
        logic [1:0] mode;
        logic [3:0] adv;
        logic tog;
        logic [3:0] tnib;
        logic tstb;
        logic tact;
        logic col;
        logic crs;
    } pmr_core_s;

    typedef struct packed {
        pmr_rx_e st;
        logic ph;
        logic [3:0] div;
        logic [3:0] nib;
        logic err;
        logic [3:0] rxd;
        logic dv;
        logic cdv;
        logic er;
        logic [3:0] tdiv;
        logic tph;
        logic [1:0] tlo;
        logic tsfd;
        logic [3:0] tnib;
        logic ttog;
        logic ten;
    } pmr_link_s;

    pmr_core_s c_q, c_d;
    pmr_link_s l_q, l_d;

    logic [4:0] strap_s;
    logic [4:0] to_link;
    logic [4:0] at_link;
    logic [1:0] at_core;
    logic fifo_wr;
    logic [FIFO_W-1:0] fifo_in;
    logic fifo_room;
    logic fifo_pop;
    logic [FIFO_W-1:0] fifo_head;
    logic [FIFO_AW:0] fifo_level;
    logic spd_now;
    logic dup_now;
    logic lrst;
    logic l_carrier;
    logic l_spd;
    logic l_rmii;
    logic l_mii;

    // Ability set for a strap combination
    function automatic logic [3:0] abilities(input logic an, input logic s, input logic d);
        logic [3:0] a;
        a = '0;
        if (an) begin
            a[ADV_100F] = s & d;
            a[ADV_100H] = s;
            a[ADV_10F] = d;
        end else begin
            a[ADV_100F] = s & d;
            a[ADV_100H] = s & ~d;
            a[ADV_10F] = ~s & d;
            a[ADV_10H] = ~s & ~d;
        end
        return a;
    endfunction

    // ---------------------------------------------------------------
    // Crossings
    // ---------------------------------------------------------------
    pmr_sync #(.W(5)) u_strap_sync (
        .clk(mclk),
        .d({autoneg_enable_strap, speed_select_strap, duplex_select_strap, mode_strap}),
        .q(strap_s)
    );

    assign to_link = {reset, phy_rx_carrier, spd_now, c_q.mode == MODE_RMII, c_q.mode == MODE_MII};

    pmr_sync #(.W(5)) u_link_sync (
        .clk(link_clk),
        .d(to_link),
        .q(at_link)
    );

    assign lrst = at_link[4];
    assign l_carrier = at_link[3];
    assign l_spd = at_link[2];
    assign l_rmii = at_link[1];
    assign l_mii = at_link[0];

    pmr_sync #(.W(2)) u_core_sync (
        .clk(mclk),
        .d({l_q.ten, l_q.ttog}),
        .q(at_core)
    );

    pmr_rx_fifo u_fifo (
        .wclk(mclk),
        .wrst(reset),
        .w_valid(fifo_wr),
        .w_data(fifo_in),
        .w_ready(fifo_room),
        .rclk(link_clk),
        .rrst(lrst),
        .r_pop(fifo_pop),
        .r_data(fifo_head),
        .r_level(fifo_level)
    );

    // ---------------------------------------------------------------
    // Core clock side
    // ---------------------------------------------------------------
    assign spd_now = c_q.an ? neg_speed100 : c_q.spd;
    assign dup_now = c_q.an ? neg_full_duplex : c_q.dup;

    always_comb begin
        fifo_in = {1'b0, phy_rx_nibble};
        if (phy_false_carrier) begin
            fifo_in = {1'b1, NIB_FALSE};
        end else if (phy_symbol_error) begin
            fifo_in = {1'b0, NIB_SYMERR};
        end
    end

    // no receive traffic unless the mode is RMII or MII
    assign fifo_wr = phy_rx_strobe && fifo_room && (c_q.mode == MODE_RMII || c_q.mode == MODE_MII)
        && (phy_rx_valid || (phy_false_carrier && spd_now));

    // Straps, defaults, transmit handoff, collision and carrier
    always_comb begin
        c_d = c_q;
        c_d.tstb = 1'b0;
        if (reset) begin
            c_d.an = strap_s[4];
            c_d.spd = strap_s[3];
            c_d.dup = strap_s[2];
            c_d.mode = strap_s[1:0];
        end
        // forced mode when autoneg strap low
        c_d.adv = abilities(c_d.an, c_d.spd, c_d.dup);
        // The nibble word is held stable far longer than the toggle takes
        c_d.tog = at_core[0];
        if (at_core[0] != c_q.tog) begin
            c_d.tnib = l_q.tnib;
            c_d.tstb = 1'b1;
        end
        c_d.tact = at_core[1];
        c_d.col = (c_q.mode == MODE_MII) && !dup_now && at_core[1] && phy_rx_valid;
        c_d.crs = (c_q.mode == MODE_MII) && (phy_rx_carrier || (!dup_now && !spd_now && at_core[1]));
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            c_q <= '0;
            c_q.an <= c_d.an;
            c_q.spd <= c_d.spd;
            c_q.dup <= c_d.dup;
            c_q.mode <= c_d.mode;
        end else begin
            c_q <= c_d;
        end
    end

    // ---------------------------------------------------------------
    // Link clock side
    // ---------------------------------------------------------------
    always_comb begin
        logic step;
        logic tstep;
        logic [1:0] dib;
        l_d = l_q;
        fifo_pop = 1'b0;
        step = 1'b0;
        tstep = 1'b0;
        dib = '0;
        // one output change per ten clocks at 10M RMII, every clock otherwise
        l_d.div = (l_q.div == HOLD_LAST || l_spd || !l_rmii) ? 4'h0 : l_q.div + 4'h1;
        step = l_spd || !l_rmii || l_q.div == HOLD_LAST;

        // all outputs below are registered on link_clk
        if (step) begin
            case (l_q.st)
                RX_IDLE: begin
                    l_d.rxd = '0;
                    l_d.dv = 1'b0;
                    l_d.cdv = 1'b0;
                    l_d.er = 1'b0;
                    if (l_carrier && (l_rmii || l_mii)) begin
                        l_d.st = RX_FILL;
                        l_d.cdv = l_rmii;
                    end else if (fifo_level != '0) begin
                        fifo_pop = 1'b1;
                    end
                end
                RX_FILL: begin
                    // wait for twelve bits in rmii
                    l_d.rxd = '0;
                    // An underrun gap shows idle, so no stale valid or error sits over zero data
                    l_d.dv = 1'b0;
                    l_d.er = 1'b0;
                    if (fifo_level >= (l_rmii ? FILL_NIBBLES : 4'h1)) begin
                        l_d.nib = fifo_head[3:0];
                        l_d.err = fifo_head[4];
                        fifo_pop = 1'b1;
                        l_d.ph = 1'b0;
                        l_d.st = RX_DATA;
                    end else if (!l_carrier && fifo_level == '0) begin
                        l_d.st = RX_IDLE;
                        l_d.cdv = 1'b0;
                    end
                end
                RX_DATA: begin
                    if (l_mii) begin
                        // false carrier shows 1110 with error
                        l_d.rxd = l_q.nib;
                        l_d.dv = !l_q.err;
                        l_d.er = l_q.err && l_spd;
                        if (fifo_level != '0) begin
                            l_d.nib = fifo_head[3:0];
                            l_d.err = fifo_head[4];
                            fifo_pop = 1'b1;
                        end else begin
                            l_d.st = l_carrier ? RX_FILL : RX_IDLE;
                        end
                    end else begin
                        dib = l_q.ph ? l_q.nib[3:2] : l_q.nib[1:0];
                        l_d.rxd = {2'h0, dib};
                        l_d.er = l_q.err && l_spd;
                        // drop on first di-bit once carrier gone
                        l_d.cdv = l_q.ph || l_carrier;
                        l_d.ph = !l_q.ph;
                        if (l_q.err && !l_carrier) begin
                            l_d.st = RX_IDLE;
                            l_d.rxd = '0;
                            l_d.er = 1'b0;
                            l_d.cdv = 1'b0;
                        end else if (l_q.ph) begin
                            if (fifo_level != '0) begin
                                l_d.nib = fifo_head[3:0];
                                l_d.err = fifo_head[4];
                                fifo_pop = 1'b1;
                            end else begin
                                l_d.st = l_carrier ? RX_FILL : RX_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    l_d.st = RX_IDLE;
                end
            endcase
        end

        // 10M di-bit sampled once per hold
        l_d.ten = tx_en && (l_rmii || l_mii);
        l_d.tdiv = (!tx_en || l_spd || l_q.tdiv == HOLD_LAST) ? 4'h0 : l_q.tdiv + 4'h1;
        tstep = tx_en && (l_spd || !l_rmii || l_q.tdiv == 4'h0);
        if (!tx_en) begin
            // partial nibble at frame end dropped
            l_d.tph = 1'b0;
            l_d.tsfd = 1'b0;
        end else if (tstep && l_mii) begin
            l_d.tnib = txd;
            l_d.ttog = !l_q.ttog;
        end else if (tstep && l_rmii) begin
            if (!l_spd && !l_q.tsfd && txd[1:0] == DIBIT_SFD) begin
                // pad so delimiter ends a nibble
                l_d.tnib = {DIBIT_SFD, DIBIT_PRE};
                l_d.ttog = !l_q.ttog;
                l_d.tph = 1'b0;
                l_d.tsfd = 1'b1;
            end else if (!l_q.tph) begin
                l_d.tlo = txd[1:0];
                l_d.tph = 1'b1;
            end else begin
                l_d.tnib = {txd[1:0], l_q.tlo};
                l_d.ttog = !l_q.ttog;
                l_d.tph = 1'b0;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs, all from flip-flops
    // ---------------------------------------------------------------
    assign adv_ability = c_q.adv;
    assign bmcr_an_enable = c_q.an;
    assign bmcr_speed100 = c_q.spd;
    assign bmcr_full_duplex = c_q.dup;
    assign phy_tx_nibble = c_q.tnib;
    assign phy_tx_strobe = c_q.tstb;
    assign phy_tx_active = c_q.tact;
    assign col = c_q.col;
    assign crs = c_q.crs;
    assign rxd = l_q.rxd;
    assign rx_dv = l_q.dv;
    assign carrier_valid_pin = l_q.cdv;
    assign rx_er = l_q.er;
endmodule

// >>> dv/pmr_port_sva.sv
// Port checker for pmr_port, attached by bind.
// Assumes straps and mode change only while reset is high.
`timescale 1ns/10ps
module pmr_port_sva (
    input wire logic mclk, // Core clock
    input wire logic reset, // Core reset
    input wire logic link_clk, // Link clock
    input wire logic [1:0] mode_strap, // Interface type
    input wire logic phy_rx_valid, // Line data valid
    input wire logic [3:0] adv_ability, // Advertised set
    input wire logic bmcr_an_enable, // Autoneg default
    input wire logic bmcr_speed100, // Speed default
    input wire logic bmcr_full_duplex, // Duplex default
    input wire logic phy_tx_strobe, // Nibble pulse
    input wire logic phy_tx_active, // Transmit busy
    input wire logic col, // Collision
    input wire logic [3:0] rxd, // Receive data
    input wire logic rx_dv, // MII valid
    input wire logic carrier_valid_pin, // RMII carrier-valid
    input wire logic rx_er // Receive error
);
    import pmr_pkg::*;
    // ----
    // Properties, one per rule
    // ----
    // negotiated advertisement
    adv_an_a: assert property (@(posedge mclk) disable iff (reset)
        !$past(reset) && !$past(reset, 2) && bmcr_an_enable |-> adv_ability == {bmcr_speed100 & bmcr_full_duplex,
        bmcr_speed100, bmcr_full_duplex, 1'h0}) else $error("advertised set wrong");
    adv_forced_a: assert property (@(posedge mclk) disable iff (reset)
        !$past(reset) && !$past(reset, 2) && !bmcr_an_enable
        |-> adv_ability == 4'h1 << {bmcr_speed100, bmcr_full_duplex}) else $error("forced ability wrong");
    straps_kept_a: assert property (@(posedge mclk) disable iff (reset)
        !$past(reset) |-> $stable({bmcr_an_enable, bmcr_speed100, bmcr_full_duplex})) else $error("defaults moved");
    false_err_data_a: assert property (@(posedge link_clk) disable iff (reset)
        rx_er |-> rxd inside {4'h2, 4'h3, 4'hE}) else $error("error without false pattern");
    rmii_upper_a: assert property (@(posedge link_clk) disable iff (reset)
        mode_strap == MODE_RMII |-> rxd[3:2] == 2'h0 && !rx_dv) else $error("unused lines active");
    mii_no_cdv_a: assert property (@(posedge link_clk) disable iff (reset)
        mode_strap == MODE_MII |-> !carrier_valid_pin) else $error("carrier-valid in MII");
    mii_idle_zero_a: assert property (@(posedge link_clk) disable iff (reset)
        mode_strap == MODE_MII && !rx_dv && !rx_er |-> rxd == 4'h0) else $error("data while not valid");
    col_cause_a: assert property (@(posedge mclk) disable iff (reset)
        col |-> $past(phy_rx_valid) && phy_tx_active && mode_strap == MODE_MII) else $error("stray collision");
    strobe_pulse_a: assert property (@(posedge mclk) disable iff (reset)
        phy_tx_strobe |=> !phy_tx_strobe) else $error("strobe too long");
endmodule

bind pmr_port pmr_port_sva i_sva (.mclk, .reset, .link_clk, .mode_strap, .phy_rx_valid, .adv_ability,
    .bmcr_an_enable, .bmcr_speed100, .bmcr_full_duplex, .phy_tx_strobe, .phy_tx_active, .col,
    .rxd, .rx_dv, .carrier_valid_pin, .rx_er);

// >>> dv/pmr_mac_model.sv
// MAC partner: drives transmit, collects the receive stream.
// Assumes the bench has set mode and speed through reset.
`timescale 1ns/10ps
module pmr_mac_model (
    input wire logic link_clk, // Reference or data clock
    input wire logic [3:0] rxd, // Receive data
    input wire logic rx_dv, // MII valid
    input wire logic carrier_valid_pin, // RMII carrier-valid
    output logic tx_en, // Transmit enable
    output logic [3:0] txd // Transmit data
);
    logic [3:0] got[$];
    logic on_q = 1'h0;
    logic cdv_q = 1'h0;
    initial tx_en = 1'h0;
    initial txd = 4'hA;
    // ----
    // Receive collection
    // ----
    // Skip fill 00s; frame opens on first 01
    always @(posedge link_clk) begin
        cdv_q <= carrier_valid_pin;
        on_q <= (carrier_valid_pin | cdv_q) & (on_q | rxd == 4'h1);
        if (rx_dv)
            got.push_back(rxd);
        else if ((carrier_valid_pin | cdv_q) & (on_q | rxd == 4'h1))
            got.push_back(rxd);
    end
    // Request held from edge to edge
    // Each unit is held h clocks; 10M RMII needs ten
    task automatic send(input logic [3:0] v[4], input int n, input int h);
        for (int i = 0; i < n; i++) begin
            repeat (h) @(posedge link_clk);
            tx_en <= 1'h1;
            txd <= v[i];
        end
        repeat (h) @(posedge link_clk);
        tx_en <= 1'h0;
        txd <= ~v[n-1]; // Released lines never repeat the last value
    endtask
endmodule

// >>> dv/pmr_port_bench.sv
// Self-checking bench for pmr_port with a MAC partner.
// Assumes a 250 MHz core clock and a 160 ns link clock.
`timescale 1ns/10ps
module pmr_port_bench;
    import pmr_pkg::*;
    logic mclk = 1'h0, link_clk = 1'h0, reset = 1'h1;
    logic autoneg_enable_strap = 1'h0, speed_select_strap = 1'h1, duplex_select_strap = 1'h1;
    logic [1:0] mode_strap = MODE_RMII;
    logic neg_speed100 = 1'h1, neg_full_duplex = 1'h1;
    logic phy_rx_carrier = 1'h0, phy_rx_valid = 1'h0, phy_rx_strobe = 1'h0;
    logic phy_false_carrier = 1'h0, phy_symbol_error = 1'h0;
    logic [3:0] phy_rx_nibble = 4'h0, adv_ability, phy_tx_nibble, txd, rxd, e;
    logic bmcr_an_enable, bmcr_speed100, bmcr_full_duplex, phy_tx_strobe, phy_tx_active;
    logic col, crs, tx_en, rx_dv, carrier_valid_pin, rx_er;
    logic [3:0] txq[$];
    logic [3:0] f[4] = '{4'h5, 4'hD, 4'h6, 4'h9};
    // Rows: straps {autoneg, speed, duplex}, then expected advertised set
    logic [6:0] rows[8] = '{7'h7E, 7'h64, 7'h52, 7'h40, 7'h38, 7'h24, 7'h12, 7'h01};
    int miscompares = 0, comparisons = 0, n_err = 0, n_col = 0, n_crs = 0, k;
    always #2 mclk = ~mclk;
    initial #1.3 forever #80 link_clk = ~link_clk;
    pmr_port i_dut (.*);
    pmr_mac_model i_mac (.link_clk, .rxd, .rx_dv, .carrier_valid_pin, .tx_en, .txd);
    // Event monitors
    always @(posedge mclk) begin
        if (phy_tx_strobe) txq.push_back(phy_tx_nibble);
        n_col += col;
        n_crs += crs;
    end
    always @(posedge link_clk) n_err += rx_er;
    // ----
    // Shared tasks
    // ----
    task chk(input logic [7:0] s, input logic [7:0] x);
        comparisons++;
        if (s !== x) begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, s, x);
        end
    endtask
    task final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reset long enough for the link side as well
    task do_reset(input logic [2:0] s, input logic [1:0] m);
        @(posedge mclk);
        reset <= 1'h1;
        {autoneg_enable_strap, speed_select_strap, duplex_select_strap} <= s;
        mode_strap <= m;
        repeat (240) @(posedge mclk);
        reset <= 1'h0;
        repeat (400) @(posedge mclk);
    endtask
    task rx_frame(input logic sym, input logic fc);
        i_mac.got.delete();
        @(posedge mclk);
        {phy_rx_carrier, phy_rx_valid, phy_false_carrier, phy_symbol_error} <= {1'h1, !fc, fc, sym};
        for (int i = 0; i < 4; i++) begin
            repeat (80) @(posedge mclk);
            phy_rx_nibble <= f[i];
            phy_rx_strobe <= 1'h1;
            @(posedge mclk);
            phy_rx_strobe <= 1'h0;
        end
        repeat (200) @(posedge mclk);
        {phy_rx_carrier, phy_rx_valid, phy_false_carrier, phy_symbol_error} <= 4'h0;
        repeat (1200) @(posedge mclk);
    endtask
    initial begin
        #300000;
        miscompares++;
        final_report;
    end
    initial begin
        foreach (rows[i]) begin
            do_reset(rows[i][6:4], MODE_RMII);
            chk(adv_ability, rows[i][3:0]);
            chk({bmcr_an_enable, bmcr_speed100, bmcr_full_duplex}, rows[i][6:4]);
        end
        do_reset(3'h3, MODE_RMII);
        for (int s = 0; s < 2; s++) begin
            k = n_err;
            rx_frame(s[0], 1'h0);
            for (int i = 0; i < 8; i++) begin
                e = f[i/2] >> (2 * (i % 2));
                chk(i_mac.got[i], s ? 4'h1 : e & 4'h3);
            end
            if (s == 0) chk(8'(n_err - k), 8'h0);
        end
        k = n_err;
        rx_frame(1'h0, 1'h1);
        chk(n_err > k, 1'h1);
        txq.delete();
        i_mac.send('{4'h1, 4'h3, 4'h2, 4'h0}, 3, 1);
        repeat (100) @(posedge mclk);
        chk(8'(txq.size()), 8'h1);
        chk(txq[0], 4'hD);
        // 10M RMII: preamble padded so the delimiter closes a nibble
        do_reset(3'h1, MODE_RMII);
        txq.delete();
        i_mac.send('{4'h1, 4'h3, 4'h2, 4'h1}, 4, 10);
        repeat (100) @(posedge mclk);
        chk(8'(txq.size()), 8'h2);
        chk({txq[0], txq[1]}, 8'hD6);
        do_reset(3'h2, MODE_MII);
        k = n_crs;
        rx_frame(1'h0, 1'h0);
        for (int i = 0; i < 4; i++) chk(i_mac.got[i], f[i]);
        chk(n_crs > k, 1'h1);
        txq.delete();
        k = n_col;
        i_mac.send('{4'hA, 4'h5, 4'h0, 4'h0}, 2, 1);
        repeat (100) @(posedge mclk);
        chk(8'(txq.size()), 8'h2);
        chk({txq[0], txq[1]}, 8'hA5);
        chk(n_col, k);
        {phy_rx_carrier, phy_rx_valid} <= 2'h3;
        i_mac.send('{4'h1, 4'h2, 4'h3, 4'h4}, 4, 1);
        repeat (100) @(posedge mclk);
        {phy_rx_carrier, phy_rx_valid} <= 2'h0;
        chk(n_col > k, 1'h1);
        // 10M half MII: own transmit alone raises carrier sense
        do_reset(3'h0, MODE_MII);
        k = n_crs;
        i_mac.send(f, 2, 1);
        repeat (20) @(posedge mclk);
        chk(n_crs > k, 1'h1);
        final_report;
    end
endmodule
